// ---- rtl/cax_top.sv ----
// Operation
// - Two-bit aux select picks the output; code 00 gives no output.
// - Decoding of aux select depends on capture select and mode code.
// - Code 01 gives time base rollover in every mode.
// - Timer mode: 10 gives special event trigger, 11 gives nothing.
// - Compare modes: 10 gives compare event, 11 gives compare waveform.
// - Capture modes: 10 mirrors the capture disable flag.
// - Capture modes: 11 gives the capture event.
// - Auxiliary output goes to the charge time measurement unit.
// - Clock select 111, 110, 101: external A, external B, logic cell.
// - Clock select 100..000: oscillator, LOW_POWER_RC_OSC, secondary, 8 MHz, system.
// - After reset the time base runs from the system clock.
// - Timer mode is capture select 0, mode 0000; capture select 1 gives the capture modes.
module cax_top
	import cax_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rollover_evt,
	input wire logic special_trig_evt,
	input wire logic compare_evt,
	input wire logic compare_out,
	input wire logic capture_evt,
	input wire logic capture_disable_flag,
	input wire logic clk_8mhz_in,
	input wire logic sec_osc_in,
	input wire logic low_power_rc_osc,
	input wire logic sys_osc_in,
	input wire logic logic_cell_one,
	input wire logic ext_clock_input_b,
	input wire logic ext_clock_input_a,
	output logic aux_out_charge_time_measure_unit,
	output logic tb_tick,
	output logic [15:0] ctrl1_q
);

	// ****************************************************************
	// State.
	// ****************************************************************
	typedef struct packed {
		logic [15:0] ctrl1;
		logic [1:0] aux_sel;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic prev_lvl;
		logic tick;
		logic stretch;
		logic aux_out;
	} cax_state_t;

	cax_state_t s_ff;
	cax_state_t nxt_s;

	logic [N_CLK_SRC-1:0] src_async;
	logic [N_CLK_SRC-1:0] src_sync;
	logic [2:0] time_base_clock_select;
	logic [3:0] mode;
	logic capsel;
	logic on;
	logic is_timer;
	logic is_compare;
	logic is_capture;
	logic sel_lvl;
	logic tick_now;
	logic ev;
	logic ev_mode;
	logic lvl_mode;
	logic lvl;

	// ****************************************************************
	// Clock source synchronisers.
	// ****************************************************************
	// Bit k holds the source chosen by clock select code k+1.
	assign src_async = {ext_clock_input_a, ext_clock_input_b,
		logic_cell_one, sys_osc_in, low_power_rc_osc, sec_osc_in,
		clk_8mhz_in};

	cax_sync #(
		.WIDTH(N_CLK_SRC)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in(src_async),
		.sync_out(src_sync)
	);

	assign time_base_clock_select = s_ff.ctrl1[B_TIME_BASE_CLOCK_SELECT_LO +: 3];
	assign mode = s_ff.ctrl1[B_MODE_LO +: 4];
	assign capsel = s_ff.ctrl1[B_CAPSEL];
	assign on = s_ff.ctrl1[B_MODULE_ON];

	// ****************************************************************
	// Mode decode and output selection.
	// ****************************************************************
	always_comb begin
		is_timer = !capsel && (mode == MODE_TIMER);
		is_compare = !capsel && (mode != MODE_TIMER);
		is_capture = capsel;
		// Sources slower than pclk give one tick per rising edge.
		sel_lvl = 1'b0;
		tick_now = 1'b1;
		if (time_base_clock_select != CLK_SYS) begin
			sel_lvl = src_sync[time_base_clock_select - 3'h1];
			tick_now = sel_lvl && !s_ff.prev_lvl;
		end
		ev_mode = 1'b0;
		ev = 1'b0;
		lvl_mode = 1'b0;
		lvl = 1'b0;
		case (s_ff.aux_sel)
			AUX_NONE: begin
				ev_mode = 1'b0;
			end
			AUX_ROLL: begin
				ev_mode = 1'b1;
				ev = rollover_evt;
			end
			AUX_SEL2: begin
				if (is_capture) begin
					lvl_mode = 1'b1;
					lvl = capture_disable_flag;
				end else begin
					ev_mode = 1'b1;
					ev = is_timer ? special_trig_evt : compare_evt;
				end
			end
			AUX_SEL3: begin
				if (is_capture) begin
					ev_mode = 1'b1;
					ev = capture_evt;
				end else if (is_compare) begin
					lvl_mode = 1'b1;
					lvl = compare_out;
				end
			end
			default: begin
				ev_mode = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// Next state: APB slave and output registers.
	// ****************************************************************
	always_comb begin
		nxt_s = s_ff;
		nxt_s.pready = 1'b0;
		nxt_s.pslverr = 1'b0;
		nxt_s.prev_lvl = sel_lvl;
		nxt_s.tick = tick_now;
		// A new event wins over the tick that would end the pulse.
		nxt_s.stretch = on && ev_mode &&
			(ev || (s_ff.stretch && !tick_now));
		nxt_s.aux_out = on && (lvl_mode ? lvl : nxt_s.stretch);
		// The answer is prepared in the setup cycle so that pready comes
		// from a flop yet the access phase never waits.
		if (psel && !penable) begin
			nxt_s.pready = 1'b1;
			nxt_s.prdata = 32'h0000_0000;
			case (paddr)
				OFS_CTRL1: begin
					nxt_s.prdata[15:0] = s_ff.ctrl1 & CTRL1_WMASK;
				end
				OFS_CTRL2H: begin
					nxt_s.prdata[B_AUX_SEL_LO +: 2] = s_ff.aux_sel;
				end
				OFS_STATUS: begin
					nxt_s.prdata[B_ST_AUX] = s_ff.aux_out;
					nxt_s.prdata[B_ST_TICK] = s_ff.tick;
					nxt_s.prdata[B_ST_TIME_BASE_CLOCK_SELECT_LO +: 3] = time_base_clock_select;
				end
				default: begin
					nxt_s.pslverr = 1'b1;
				end
			endcase
		end
		if (psel && penable && s_ff.pready && pwrite && !s_ff.pslverr) begin
			case (paddr)
				OFS_CTRL1: begin
					nxt_s.ctrl1 = pwdata[15:0] & CTRL1_WMASK;
				end
				OFS_CTRL2H: begin
					nxt_s.aux_sel = pwdata[B_AUX_SEL_LO +: 2];
				end
				default: begin
					nxt_s.ctrl1 = s_ff.ctrl1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
			s_ff.ctrl1 <= CTRL1_RESET;
			s_ff.aux_sel <= AUX_SEL_RESET;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign aux_out_charge_time_measure_unit = s_ff.aux_out;
	assign tb_tick = s_ff.tick;
	assign ctrl1_q = s_ff.ctrl1;

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_roll_hit;
		on && s_ff.aux_sel == AUX_ROLL && time_base_clock_select == CLK_SYS && rollover_evt;
	endsequence

	sequence s_roll_quiet;
		on && s_ff.aux_sel == AUX_ROLL && time_base_clock_select == CLK_SYS && !rollover_evt;
	endsequence

	// The last high cycle of a rollover followed by a quiet cycle.
	sequence s_single_roll;
		s_roll_hit ##1 s_roll_quiet;
	endsequence

	a_aux_off_sel: assert property (
		$past(s_ff.aux_sel) == AUX_NONE |-> !aux_out_charge_time_measure_unit)
		else $error("aux output active with select 00");

	a_module_off: assert property (
		!$past(on) |-> !aux_out_charge_time_measure_unit)
		else $error("aux output active while module off");

	a_roll_route: assert property (
		on && s_ff.aux_sel == AUX_ROLL && rollover_evt |=> aux_out_charge_time_measure_unit)
		else $error("rollover not routed to aux output");

	a_timer_trig: assert property (
		on && is_timer && s_ff.aux_sel == AUX_SEL2 && special_trig_evt
		|=> aux_out_charge_time_measure_unit)
		else $error("special trigger not routed in timer mode");

	a_timer_none: assert property (
		is_timer && s_ff.aux_sel == AUX_SEL3 |=> !aux_out_charge_time_measure_unit)
		else $error("timer mode select 11 drives aux output");

	a_cmp_route: assert property (
		on && is_compare && s_ff.aux_sel == AUX_SEL3
		|=> aux_out_charge_time_measure_unit == $past(compare_out))
		else $error("compare waveform not mirrored");

	a_cmp_event: assert property (
		on && is_compare && s_ff.aux_sel == AUX_SEL2 && compare_evt
		|=> aux_out_charge_time_measure_unit)
		else $error("compare event not routed");

	a_capture_disable_flag_mirror: assert property (
		on && is_capture && s_ff.aux_sel == AUX_SEL2
		|=> aux_out_charge_time_measure_unit == $past(capture_disable_flag))
		else $error("capture disable flag not mirrored");

	a_cap_event: assert property (
		on && is_capture && s_ff.aux_sel == AUX_SEL3 && capture_evt
		|=> aux_out_charge_time_measure_unit)
		else $error("capture event not routed");

	a_pulse_width: assert property (
		s_single_roll |-> aux_out_charge_time_measure_unit ##1 !aux_out_charge_time_measure_unit)
		else $error("event pulse not one time base clock wide");

	a_sys_tick: assert property (
		time_base_clock_select == CLK_SYS |=> tb_tick)
		else $error("system clock time base does not tick each cycle");

endmodule

// ---- shared/cax_pkg.sv ----
package cax_pkg;

	// ****************************************************************
	// Register map, byte addresses on the APB.
	// ****************************************************************
	localparam int ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_CTRL1 = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_CTRL2H = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h008;

	// ****************************************************************
	// Field positions of module_control_one_low.
	// ****************************************************************
	localparam int B_MODULE_ON = 15;
	localparam int B_IDLE_STOP = 13;
	localparam int B_SLEEP_RUN = 12;
	localparam int B_TB_SYNC = 11;
	localparam int B_TIME_BASE_CLOCK_SELECT_LO = 8;
	localparam int B_PRESCALE_LO = 6;
	localparam int B_WIDE_TB = 5;
	localparam int B_CAPSEL = 4;
	localparam int B_MODE_LO = 0;
	localparam logic [15:0] CTRL1_RESET = 16'h0000;
	localparam logic [15:0] CTRL1_WMASK = 16'hBFFF;

	// ****************************************************************
	// Fields of control_two_high and of the status word.
	// ****************************************************************
	localparam int B_AUX_SEL_LO = 3;
	localparam logic [1:0] AUX_SEL_RESET = 2'h0;
	localparam int B_ST_AUX = 0;
	localparam int B_ST_TICK = 1;
	localparam int B_ST_TIME_BASE_CLOCK_SELECT_LO = 2;

	// ****************************************************************
	// Encodings.
	// ****************************************************************
	localparam logic [1:0] AUX_NONE = 2'h0;
	localparam logic [1:0] AUX_ROLL = 2'h1;
	localparam logic [1:0] AUX_SEL2 = 2'h2;
	localparam logic [1:0] AUX_SEL3 = 2'h3;
	localparam logic [3:0] MODE_TIMER = 4'h0;
	localparam logic [2:0] CLK_SYS = 3'h0;
	localparam logic [2:0] CLK_8MHZ = 3'h1;
	localparam logic [2:0] CLK_SOSC = 3'h2;
	localparam logic [2:0] CLK_LOW_POWER_RC_OSC = 3'h3;
	localparam logic [2:0] CLK_FOSC = 3'h4;
	localparam logic [2:0] CLK_LCELL1 = 3'h5;
	localparam logic [2:0] CLK_EXT_B = 3'h6;
	localparam logic [2:0] CLK_EXT_A = 3'h7;
	localparam int N_CLK_SRC = 7;

endpackage

// ---- rtl/cax_sync.sv ----
module cax_sync #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} cax_sync_t;

	cax_sync_t s_ff;
	cax_sync_t nxt_s;

	if (WIDTH < 1) begin : g_chk
		$error("cax_sync needs WIDTH of at least one");
	end

	// Only the second stage is read outside; the first may go metastable.
	always_comb begin
		nxt_s = s_ff;
		nxt_s.meta = async_in;
		nxt_s.stable = s_ff.meta;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign sync_out = s_ff.stable;

endmodule

// ---- dv/cax_peer.sv ----
module cax_peer (
	input wire logic pclk,
	input wire logic presetn,
	output logic [6:0] src_clk
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************************************
	// Clock sources of the neighbouring peripherals.
	// ****************************************************************
	// Source k toggles every k+1 cycles, so that each clock selection
	// has its own period and a wrong mapping shows up in the tick rate.
	logic [3:0] cnt_ff [7];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			src_clk <= 7'h00;
			for (int k = 0; k < 7; k++) cnt_ff[k] <= 4'h0;
		end else begin
			for (int k = 0; k < 7; k++) begin
				if (cnt_ff[k] == 4'(k)) begin
					cnt_ff[k] <= 4'h0;
					src_clk[k] <= ~src_clk[k];
				end else begin
					cnt_ff[k] <= cnt_ff[k] + 4'h1;
				end
			end
		end
	end
endmodule

// ---- dv/ccp_aux_output_and_clock_select_tb.sv ----
module ccp_aux_output_and_clock_select_tb
	import cax_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic aux_out_charge_time_measure_unit, tb_tick;
	logic [15:0] ctrl1_q;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0] ev;
	logic [6:0] src;
	int miscompares, cmp_count, cnt, x;
	logic [7:0] mw [4] = '{8'h00, 8'h01, 8'h0F, 8'h15};

	cax_top i_cax_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.rollover_evt(ev[0]), .special_trig_evt(ev[1]),
		.compare_evt(ev[2]), .compare_out(ev[3]), .capture_evt(ev[4]),
		.capture_disable_flag(ev[5]), .clk_8mhz_in(src[0]),
		.sec_osc_in(src[1]), .low_power_rc_osc(src[2]),
		.sys_osc_in(src[3]), .logic_cell_one(src[4]),
		.ext_clock_input_b(src[5]), .ext_clock_input_a(src[6]),
		.aux_out_charge_time_measure_unit(aux_out_charge_time_measure_unit), .tb_tick(tb_tick), .ctrl1_q(ctrl1_q));

	cax_peer i_cax_peer (.pclk(pclk), .presetn(presetn), .src_clk(src));

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	task automatic chk(input string n, input logic [31:0] xv,
		input logic [31:0] g);
		cmp_count++;
		if (g !== xv) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", n, xv, g);
		end
	endtask

	// The request stands until pready is seen high at a rising edge; only
	// the watchdog ends a wait, so a slave that never answers still fails.
	task automatic rw(input logic w, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [31:0] xq, input logic xe);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		if (!w) chk("prdata", xq, prdata);
		chk("pslverr", xe, pslverr);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Class 0 timer, 1 and 2 compare, 3 capture; k indexes ev.
	function automatic logic expv(input int m, input int s, input int k);
		if (s == 0) return 1'b0;
		if (s == 1) return k == 0;
		if (m == 0) return s == 2 && k == 1;
		if (m == 3) return (s == 2 && k == 5) || (s == 3 && k == 4);
		return (s == 2 && k == 2) || (s == 3 && k == 3);
	endfunction

	task automatic summarize();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		summarize();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h0;
		ev = 6'h00;
		miscompares = 0;
		cmp_count = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		rw(1'b0, OFS_CTRL1, 32'h0, {16'h0, CTRL1_RESET}, 1'b0);
		rw(1'b0, OFS_STATUS, 32'h0, 32'h2, 1'b0);
		rw(1'b0, OFS_CTRL2H, 32'h0, 32'h0, 1'b0);
		rw(1'b1, OFS_CTRL1, 32'hFFFF, 32'h0, 1'b0);
		@(negedge pclk);
		chk("ctrl1_q", {16'h0, CTRL1_WMASK}, {16'h0, ctrl1_q});
		rw(1'b0, OFS_CTRL1, 32'h0, {16'h0, CTRL1_WMASK}, 1'b0);
		rw(1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1);
		rw(1'b1, 12'hFFC, 32'h5, 32'h0, 1'b1);
		for (int m = 0; m < 4; m++) begin
			rw(1'b1, OFS_CTRL1, {24'h80, mw[m]}, 32'h0, 1'b0);
			for (int s = 0; s < 4; s++) begin
				rw(1'b1, OFS_CTRL2H, 32'(s << 3), 32'h0, 1'b0);
				for (int k = 0; k < 6; k++) begin
					@(posedge pclk);
					ev <= 6'(1 << k);
					repeat (3) @(posedge pclk);
					@(negedge pclk);
					chk("aux", expv(m, s, k), aux_out_charge_time_measure_unit);
					@(posedge pclk);
					ev <= 6'h00;
					repeat (3) @(posedge pclk);
				end
			end
		end
		rw(1'b1, OFS_CTRL1, 32'h8000, 32'h0, 1'b0);
		rw(1'b1, OFS_CTRL2H, 32'h8, 32'h0, 1'b0);
		@(posedge pclk);
		ev <= 6'h01;
		@(posedge pclk);
		ev <= 6'h00;
		cnt = 0;
		repeat (6) begin
			@(negedge pclk);
			if (aux_out_charge_time_measure_unit === 1'b1) cnt++;
		end
		chk("pulse width", 1, cnt);
		rw(1'b1, OFS_CTRL1, 32'h0, 32'h0, 1'b0);
		@(posedge pclk);
		ev <= 6'h3F;
		repeat (3) @(posedge pclk);
		@(negedge pclk);
		chk("aux off", 0, aux_out_charge_time_measure_unit);
		@(posedge pclk);
		ev <= 6'h00;
		for (int s = 1; s < 8; s++) begin
			rw(1'b1, OFS_CTRL1, 32'h8000 | (s << 8), 32'h0, 1'b0);
			repeat (10) @(posedge pclk);
			cnt = 0;
			repeat (120) begin
				@(negedge pclk);
				if (tb_tick === 1'b1) cnt++;
			end
			x = 60 / s;
			chk("tick count", 1, 32'(cnt >= x && cnt <= x + 1));
		end
		summarize();
	end
endmodule
